// [logic/fifo_host_pkg.sv]
// Package for the strobe-driven FIFO host controller
package fifo_host_pkg;
  localparam int DATA_W = 9;
  localparam int APB_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_RDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_TIMING = 8'h10;
  // Control register bits (write pulses except mode bits)
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_REPLAY = 1;
  localparam int CTRL_WRITE = 2;
  localparam int CTRL_READ = 3;
  localparam int CTRL_DEPTH = 4;
  localparam int CTRL_LEAD = 5;
  // Status register bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_VACANT = 1;
  localparam int STAT_BRIM = 2;
  localparam int STAT_MID = 3;
  localparam int STAT_RVALID = 4;
  localparam int STAT_REFUSED = 5;
  // Timing: strobe low, clear/replay low and recovery times in ns at 4 ns per cycle
  localparam int CLK_NS = 4;
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_NS = 25;
  localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_NS = 15;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CNT_W8 = 8'hff;

  typedef enum {
    ST_IDLE, ST_CLR_LOW, ST_RPL_LOW, ST_WR_LOW, ST_RD_LOW, ST_RECOVER
  } seq_e;

  // Pins driven toward the FIFO
  typedef struct packed {
    logic write_strobe_n;
    logic read_strobe_n;
    logic pointer_clear_n;
    logic replay_request_n;
    logic lead_device_select_n;
    logic chain_input_n;
    logic [DATA_W-1:0] wdata;
  } fifo_drive_s;

  // Pins sampled from the FIFO
  typedef struct packed {
    logic vacant_flag_n;
    logic brimming_flag_n;
    logic midpoint_flag_n;
    logic [DATA_W-1:0] rdata;
  } fifo_sense_s;
endpackage

// [logic/fifo_host.sv]
// Host controller that drives a strobe FIFO or FIFO chain from APB registers
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module fifo_host #(
  parameter int DATA_W = fifo_host_pkg::DATA_W,
  parameter int CHAIN_N = 1
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fifo_host_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO control pins
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic pointer_clear_n,
  output logic replay_request_n,
  output logic [CHAIN_N-1:0] lead_device_select_n,
  output logic chain_input_n,
  output logic [DATA_W-1:0] fifo_wdata,
  // FIFO flag and data pins: vacant and brimming flags one per chained device, midpoint flag and data shared
  input wire logic [CHAIN_N-1:0] vacant_flag_n,
  input wire logic [CHAIN_N-1:0] brimming_flag_n,
  input wire logic midpoint_flag_n,
  input wire logic [DATA_W-1:0] fifo_rdata
);
  if (DATA_W < 1 || DATA_W > 32) begin : bad_data_w
    $error("DATA_W out of range");
  end
  if (CHAIN_N < 1) begin : bad_chain_n
    $error("CHAIN_N must be at least 1");
  end

  // Two-flop synchronisers on all pins from the FIFO
  logic [CHAIN_N-1:0] vac_s1_reg, vac_s2_reg, brim_s1_reg, brim_s2_reg;
  logic mid_s1_reg, mid_s2_reg;
  logic [DATA_W-1:0] rd_s1_reg, rd_s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vac_s1_reg <= '0;
      vac_s2_reg <= '0;
      brim_s1_reg <= '1;
      brim_s2_reg <= '1;
      mid_s1_reg <= 1'b1;
      mid_s2_reg <= 1'b1;
      rd_s1_reg <= '0;
      rd_s2_reg <= '0;
    end else begin
      vac_s1_reg <= vacant_flag_n;
      vac_s2_reg <= vac_s1_reg;
      brim_s1_reg <= brimming_flag_n;
      brim_s2_reg <= brim_s1_reg;
      mid_s1_reg <= midpoint_flag_n;
      mid_s2_reg <= mid_s1_reg;
      rd_s1_reg <= fifo_rdata;
      rd_s2_reg <= rd_s1_reg;
    end
  end

  // Composite flags: active-low flags ORed so any device's high releases
  logic any_room, any_data;
  assign any_room = |brim_s2_reg;
  assign any_data = |vac_s2_reg;

  // Registers
  logic depth_mode_reg, lead_reg, refused_reg, rvalid_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  fifo_host_pkg::seq_e state_reg;
  logic [7:0] cnt_reg;

  logic wr_access, rd_access, addr_ok, busy;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign busy = state_reg != fifo_host_pkg::ST_IDLE;
  assign addr_ok = paddr == fifo_host_pkg::OFS_CTRL || paddr == fifo_host_pkg::OFS_WDATA
    || paddr == fifo_host_pkg::OFS_RDATA || paddr == fifo_host_pkg::OFS_STATUS
    || paddr == fifo_host_pkg::OFS_TIMING;

  logic go_clear, go_replay, go_write, go_read;
  assign go_clear = wr_access && paddr == fifo_host_pkg::OFS_CTRL
    && pwdata[fifo_host_pkg::CTRL_CLEAR];
  assign go_replay = wr_access && paddr == fifo_host_pkg::OFS_CTRL
    && pwdata[fifo_host_pkg::CTRL_REPLAY] && !depth_mode_reg;
  assign go_write = wr_access && paddr == fifo_host_pkg::OFS_CTRL
    && pwdata[fifo_host_pkg::CTRL_WRITE];
  assign go_read = wr_access && paddr == fifo_host_pkg::OFS_CTRL
    && pwdata[fifo_host_pkg::CTRL_READ];

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // The access phase is taken on the edge where pready is high
  logic take;
  assign take = pready && psel && penable;

  // Mode and write data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_mode_reg <= 1'b0;
      lead_reg <= 1'b1;
      wdata_reg <= '0;
    end else if (take && wr_access && !pslverr) begin
      if (paddr == fifo_host_pkg::OFS_CTRL && !busy) begin
        depth_mode_reg <= pwdata[fifo_host_pkg::CTRL_DEPTH];
        lead_reg <= pwdata[fifo_host_pkg::CTRL_LEAD];
      end
      if (paddr == fifo_host_pkg::OFS_WDATA) begin
        wdata_reg <= pwdata[DATA_W-1:0];
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        fifo_host_pkg::OFS_CTRL: prdata <= {26'h0, lead_reg, depth_mode_reg, 4'h0};
        fifo_host_pkg::OFS_WDATA: prdata <= 32'(wdata_reg);
        fifo_host_pkg::OFS_RDATA: prdata <= 32'(rdata_reg);
        fifo_host_pkg::OFS_STATUS: prdata <= {26'h0, refused_reg, rvalid_reg,
          mid_s2_reg, any_room, any_data, busy};
        fifo_host_pkg::OFS_TIMING: prdata <= {24'h0, 8'(fifo_host_pkg::STROBE_CYC)};
        default: prdata <= '0;
      endcase
    end
  end

  // Strobe sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fifo_host_pkg::ST_IDLE;
      cnt_reg <= '0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      pointer_clear_n <= 1'b1;
      replay_request_n <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      refused_reg <= 1'b0;
    end else begin
      case (state_reg)
        fifo_host_pkg::ST_IDLE: begin
          cnt_reg <= '0;
          if (take && go_clear) begin
            pointer_clear_n <= 1'b0;
            state_reg <= fifo_host_pkg::ST_CLR_LOW;
            rvalid_reg <= 1'b0;
            refused_reg <= 1'b0;
          end else if (take && go_replay) begin
            replay_request_n <= 1'b0;
            state_reg <= fifo_host_pkg::ST_RPL_LOW;
          end else if (take && go_write) begin
            if (any_room) begin
              write_strobe_n <= 1'b0;
              state_reg <= fifo_host_pkg::ST_WR_LOW;
            end else begin
              refused_reg <= 1'b1;
            end
          end else if (take && go_read) begin
            if (any_data) begin
              read_strobe_n <= 1'b0;
              state_reg <= fifo_host_pkg::ST_RD_LOW;
            end else begin
              refused_reg <= 1'b1;
            end
          end
        end
        fifo_host_pkg::ST_CLR_LOW: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg >= 8'(fifo_host_pkg::RESET_CYC - 1)) begin
            pointer_clear_n <= 1'b1;
            cnt_reg <= '0;
            state_reg <= fifo_host_pkg::ST_RECOVER;
          end
        end
        fifo_host_pkg::ST_RPL_LOW: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg >= 8'(fifo_host_pkg::RESET_CYC - 1)) begin
            replay_request_n <= 1'b1;
            cnt_reg <= '0;
            state_reg <= fifo_host_pkg::ST_RECOVER;
          end
        end
        fifo_host_pkg::ST_WR_LOW: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg >= 8'(fifo_host_pkg::STROBE_CYC - 1)) begin
            write_strobe_n <= 1'b1;
            cnt_reg <= '0;
            state_reg <= fifo_host_pkg::ST_RECOVER;
          end
        end
        fifo_host_pkg::ST_RD_LOW: begin
          cnt_reg <= cnt_reg + 8'h01;
          // Data valid late in the strobe, caught before it rises
          if (cnt_reg >= 8'(fifo_host_pkg::STROBE_CYC - 1)) begin
            rdata_reg <= rd_s2_reg;
            rvalid_reg <= 1'b1;
            read_strobe_n <= 1'b1;
            cnt_reg <= '0;
            state_reg <= fifo_host_pkg::ST_RECOVER;
          end
        end
        fifo_host_pkg::ST_RECOVER: begin
          cnt_reg <= cnt_reg + 8'h01;
          // Lets flags settle through the synchronisers
          if (cnt_reg >= 8'(fifo_host_pkg::RECOV_CYC + 2)) begin
            cnt_reg <= '0;
            state_reg <= fifo_host_pkg::ST_IDLE;
          end
        end
        default: state_reg <= fifo_host_pkg::ST_IDLE;
      endcase
    end
  end

  // Static expansion pins and the write data bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_input_n <= 1'b0;
      lead_device_select_n <= '1;
      fifo_wdata <= '0;
    end else begin
      chain_input_n <= 1'b0;
      // Device 0 leads in depth mode, others held high
      for (int i = 0; i < CHAIN_N; i++) begin
        lead_device_select_n[i] <= depth_mode_reg ? (i != 0) : lead_reg;
      end
      fifo_wdata <= wdata_reg;
    end
  end
endmodule

// [testbench/fifo_model.sv]
// Behavioural strobe FIFO on the far side of the host controller
`timescale 1ns/1ns
module fifo_model #(
  parameter int DEPTH = 4
) (
  // Control pins
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic pointer_clear_n,
  input wire logic replay_request_n,
  input wire logic chain_input_n,
  input wire logic [8:0] wdata,
  // Flags and data
  output logic vacant_flag_n,
  output logic brimming_flag_n,
  output logic midpoint_flag_n,
  output logic [8:0] rdata
);
  logic [8:0] mem [DEPTH];
  int wp = 0;
  int rp = 0;
  assign vacant_flag_n = wp != rp;
  assign brimming_flag_n = wp - rp != DEPTH;
  assign midpoint_flag_n = wp - rp <= DEPTH / 2;
  initial rdata = 9'h0aa;
  always @(negedge pointer_clear_n) begin
    wp = 0;
    rp = 0;
  end
  always @(negedge replay_request_n)
    if (pointer_clear_n && !chain_input_n) rp = 0;
  always @(posedge write_strobe_n)
    // Grounded chain input: sole device, holds both tokens
    if (pointer_clear_n && brimming_flag_n && !chain_input_n) begin
      mem[wp % DEPTH] = wdata;
      wp++;
    end
  always @(negedge read_strobe_n)
    if (vacant_flag_n) begin
      rdata = mem[rp % DEPTH];
      rp++;
    end
  // Released bus shows a changed value, not the old word
  always @(posedge read_strobe_n) rdata = ~rdata;
endmodule

// [testbench/fifo_host_assertions.sv]
// Checker of pin timing at the host controller ports
`timescale 1ns/1ns
module fifo_host_checker #(
  parameter int DATA_W = 9
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  // FIFO pins
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic pointer_clear_n,
  input wire logic replay_request_n,
  input wire logic chain_input_n,
  input wire logic [DATA_W-1:0] fifo_wdata
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_chain_grounded: assert property (!chain_input_n)
    else $error("chain input not grounded");
  chk_write_width: assert property ($fell(write_strobe_n) |->
    !write_strobe_n [*7] ##1 write_strobe_n) else $error("write strobe width");
  chk_read_width: assert property ($fell(read_strobe_n) |->
    !read_strobe_n [*7] ##1 read_strobe_n) else $error("read strobe width");
  chk_clear_width: assert property ($fell(pointer_clear_n) |->
    (!pointer_clear_n && write_strobe_n && read_strobe_n) [*7] ##1 pointer_clear_n)
    else $error("clear pulse wrong");
  chk_replay_quiet: assert property ($fell(replay_request_n) |->
    (!replay_request_n && write_strobe_n && read_strobe_n) [*7] ##1 replay_request_n)
    else $error("replay pulse wrong");
  chk_data_steady: assert property (!write_strobe_n |-> $stable(fifo_wdata))
    else $error("write data moved");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_error_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind fifo_host fifo_host_checker #(.DATA_W(DATA_W)) checker_i (.pclk(pclk),
  .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .pointer_clear_n(pointer_clear_n), .replay_request_n(replay_request_n),
  .chain_input_n(chain_input_n), .fifo_wdata(fifo_wdata));

// [testbench/tb.sv]
// Self-checking bench for the FIFO host controller
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic pop; logic [8:0] val; logic [1:0] flags;} row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, st, mode;
  logic wr_n, rd_n, clr_n, rpl_n, lead_n, chain_n, vac_n, brim_n, mid_n;
  logic [8:0] wd, rdd;
  int fails, samples_checked;
  row_s rows [8];
  fifo_host fifo_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_strobe_n(wr_n), .read_strobe_n(rd_n),
    .pointer_clear_n(clr_n), .replay_request_n(rpl_n), .lead_device_select_n(lead_n),
    .chain_input_n(chain_n), .fifo_wdata(wd), .vacant_flag_n(vac_n),
    .brimming_flag_n(brim_n), .midpoint_flag_n(mid_n), .fifo_rdata(rdd));
  fifo_model fifo_model_i (.write_strobe_n(wr_n), .read_strobe_n(rd_n),
    .pointer_clear_n(clr_n), .replay_request_n(rpl_n), .chain_input_n(chain_n),
    .wdata(wd), .vacant_flag_n(vac_n), .brimming_flag_n(brim_n),
    .midpoint_flag_n(mid_n), .rdata(rdd));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Command then poll status until idle
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, fifo_host_pkg::OFS_CTRL, c);
    do begin
      apb(1'b0, fifo_host_pkg::OFS_STATUS, 32'h0);
    end while (r[fifo_host_pkg::STAT_BUSY] !== 1'b0);
    st = r;
  endtask
  task automatic push(input logic [8:0] v);
    apb(1'b1, fifo_host_pkg::OFS_WDATA, {23'h0, v});
    cmd(mode | 32'h4);
  endtask
  task automatic pop();
    cmd(mode | 32'h8);
    apb(1'b0, fifo_host_pkg::OFS_RDATA, 32'h0);
  endtask
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 32'h0;
    rows = '{'{1'b0, 9'h1a5, 2'b11}, '{1'b0, 9'h05a, 2'b11}, '{1'b0, 9'h100, 2'b11},
      '{1'b0, 9'h0ff, 2'b01}, '{1'b1, 9'h1a5, 2'b11}, '{1'b1, 9'h05a, 2'b11},
      '{1'b1, 9'h100, 2'b11}, '{1'b1, 9'h0ff, 2'b10}};
    repeat (20) @(posedge pclk);
    chk({31'h0, wr_n & rd_n & clr_n & rpl_n}, 32'h1, "idle pins");
    presetn <= 1'b1;
    cmd(32'h1);
    chk(st[2:1], 2'b10, "flags after clear");
    chk(st[3], 1'b1, "midpoint after clear");
    chk(st[4], 1'b0, "no read valid after clear");
    foreach (rows[i]) begin
      if (rows[i].pop)
        pop();
      else
        push(rows[i].val);
      chk(st[2:1], rows[i].flags, "flags");
      if (rows[i].pop) chk(r[8:0], rows[i].val, "read word");
    end
    cmd(32'h8);
    chk(st[5], 1'b1, "refused read");
    cmd(32'h1);
    chk(st[5], 1'b0, "refused cleared");
    for (int k = 1; k < 5; k++) push(9'(k * 9'h011));
    push(9'h155);
    chk(st[5], 1'b1, "refused write");
    chk(st[3], 1'b0, "midpoint when full");
    pop();
    chk(r[8:0], 9'h011, "first word");
    chk(st[4], 1'b1, "read valid");
    cmd(32'h2);
    pop();
    chk(r[8:0], 9'h011, "replayed word");
    mode = 32'h10;
    cmd(mode);
    chk(lead_n, 1'b0, "lead in depth");
    pop();
    cmd(mode | 32'h2);
    pop();
    chk(r[8:0], 9'h033, "no replay in depth");
    mode = 32'h20;
    cmd(mode);
    chk(lead_n, 1'b1, "lead level");
    chk(chain_n, 1'b0, "chain input");
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1, "unmapped error");
    apb(1'b0, fifo_host_pkg::OFS_TIMING, 32'h0);
    chk(r, 32'(fifo_host_pkg::STROBE_CYC), "timing");
    // Reset cut into a running write strobe
    apb(1'b1, fifo_host_pkg::OFS_CTRL, 32'h4);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, wr_n & rd_n & clr_n & rpl_n}, 32'h1, "pins in reset");
    chk({31'h0, pready | chain_n}, 32'h0, "bus in reset");
    chk(lead_n, 1'b1, "lead in reset");
    presetn <= 1'b1;
    cmd(32'h1);
    chk(st[4:1], 4'b0110, "status after reset");
    push(9'h1c3);
    pop();
    chk(r[8:0], 9'h1c3, "word after reset");
    give_verdict();
  end
endmodule
